// File: hw/pwm_timer_defs.vh
`ifndef PWM_TIMER_DEFS_VH
`define PWM_TIMER_DEFS_VH

// register indices (printed offsets are register indices; byte address = 4 x index)
`define IDX_INT_CONTROL      8'h0B
`define IDX_IRQ_FLAGS        8'h0C
`define IDX_TIMER_B_COUNT    8'h11
`define IDX_TIMER_B_CONTROL  8'h12
`define IDX_DUTY_HIGH_BITS   8'h15
`define IDX_DUTY_SHADOW      8'h16
`define IDX_CAPCMP_CONTROL   8'h17
`define IDX_PORT_C_DIRECTION 8'h87
`define IDX_IRQ_ENABLES      8'h8C
`define IDX_PERIOD_LIMIT     8'h92

// reset values
`define RST_ZERO             8'h00
`define RST_PORT_C_DIRECTION 8'hFF
`define RST_PERIOD_LIMIT     8'hFF

// implemented-bit masks
`define MASK_TIMER_B_CONTROL 8'h7F
`define MASK_CAPCMP_CONTROL  8'h3F
`define MASK_IRQ             8'h4F

// field positions
`define TBC_RUN              2
`define TBC_PS_HI            1
`define TBC_PS_LO            0
`define CCP_DUTY_HI          5
`define CCP_DUTY_LO          4
`define CCP_MODE_HI          3
`define CCP_MODE_LO          2
`define PWM_MODE_VAL         2'h3
`define PWM_PIN_BIT          2
`define IRQ_MATCH_BIT        1
`define IRQ_CCP_BIT          2
`define INTC_GIE             7
`define INTC_PEIE            6

// prescale codes
`define PS_DIV1              2'h0
`define PS_DIV4              2'h1
`define PS_CNT_W             4
`define QCLK_LAST            2'h3

`endif

// File: hw/prescaler.v
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timer_defs.vh"

// instruction-cycle quarter clock plus 1/4/16 prescaler
module prescaler (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // control
    input  wire       run,
    input  wire [1:0] sel,
    input  wire       clear,
    // status
    output reg        tick,
    output wire [1:0] sub_bits
);

    reg  [1:0]           qclk_q;
    reg  [`PS_CNT_W-1:0] cnt_q;
    wire                 cyc = (qclk_q == `QCLK_LAST);
    wire [`PS_CNT_W-1:0] top = (sel == `PS_DIV1) ? 4'h0 :
                               (sel == `PS_DIV4) ? 4'h3 : 4'hF; // R5

    // two low-order bits extending the count: q clock at 1:1, prescaler bits otherwise
    assign sub_bits = (sel == `PS_DIV1) ? qclk_q :
                      (sel == `PS_DIV4) ? cnt_q[1:0] : cnt_q[3:2]; // R10

    // combinational so the count steps on the same edge the low bits wrap
    always @* begin
        tick = run && cyc && (cnt_q >= top) && !clear; // R13
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qclk_q <= 2'h0;
            cnt_q  <= 4'h0;
        end else begin
            qclk_q <= qclk_q + 2'h1;
            if (clear) begin
                cnt_q <= 4'h0;
            end else if (run && cyc) begin // R13
                if (cnt_q >= top) begin
                    cnt_q <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: hw/pwm_timer_setup.v
// Function
// R1 - software sets period, duty, pin direction, prescaler and run, then PWM mode.
// R2 - the duty is duty_high_bits as upper eight bits plus capcmp_control bits 5:4.
// R3 - the waveform reaches the pin only while port_c_direction bit 2 is clear.
// R4 - timer_b_control holds prescale select and run enable; the timer counts only when run.
// R5 - the prescaler divides by 1, 4 or 16 from the two-bit select field.
// R6 - a period limit of 0xFF gives full 10-bit duty resolution, smaller limits fewer steps.
// R7 - unimplemented bits read as zero and ignore writes.
// R8 - port_c_direction resets to all ones.
// R9 - at count equal to period, the next increment clears it, sets the pin unless duty is zero, loads the shadow.
// R10 - the pin clears when the shadow duty equals the count extended by two low bits.
// R11 - a duty above the period keeps the pin high the whole period.
// R12 - writing zero to capcmp_control forces the PWM latch low, port latch untouched.
// R13 - the timer advances once per prescaled instruction cycle while running.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_timer_defs.vh"

module pwm_timer_setup (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // pin
    output reg         pwm_out_pin,
    output reg         pwm_out_pin_oe,
    // interrupt
    output reg         irq
);

    reg  [7:0] int_control_q;
    reg  [7:0] periph_irq_flags_q;
    reg  [7:0] periph_irq_enables_q;
    reg  [7:0] timer_b_count_q;
    reg  [7:0] timer_b_control_q;
    reg  [7:0] duty_high_bits_q;
    reg  [7:0] duty_shadow_q;
    reg  [1:0] duty_low_shadow_q;
    reg  [7:0] capcmp_control_q;
    reg  [7:0] port_c_direction_q;
    reg  [7:0] pwm_period_limit_q;
    reg        pwm_latch_q;

    wire       tick;
    wire [1:0] sub_bits;
    wire       pwm_mode = (capcmp_control_q[`CCP_MODE_HI:`CCP_MODE_LO] == `PWM_MODE_VAL);
    wire       acc      = psel && penable;
    wire       wr       = acc && pwrite;
    wire [9:0] idx      = paddr[11:2];
    wire       period_end = tick && (timer_b_count_q == pwm_period_limit_q);
    wire [9:0] duty_new = {duty_high_bits_q,
                           capcmp_control_q[`CCP_DUTY_HI:`CCP_DUTY_LO]}; // R2
    wire [9:0] duty_cur = {duty_shadow_q, duty_low_shadow_q};
    wire [9:0] cnt_ext  = {timer_b_count_q, sub_bits}; // R6
    // the pin drops on the edge that ends the match cycle, the same edge that clears the latch
    wire       duty_hit = (duty_cur == cnt_ext); // R10
    wire       wr_tmr   = wr && hit(`IDX_TIMER_B_COUNT);
    wire       wr_tbc   = wr && hit(`IDX_TIMER_B_CONTROL);

    function hit;
        input [7:0] i;
        begin
            hit = (idx == {2'b00, i});
        end
    endfunction

    prescaler u_prescaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (timer_b_control_q[`TBC_RUN]), // R4
        .sel      (timer_b_control_q[`TBC_PS_HI:`TBC_PS_LO]),
        .clear    (wr_tmr || wr_tbc),
        .tick     (tick),
        .sub_bits (sub_bits)
    );

    // timer and pwm latch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_b_count_q   <= `RST_ZERO;
            duty_shadow_q     <= `RST_ZERO;
            duty_low_shadow_q <= 2'h0;
            pwm_latch_q       <= 1'b0;
        end else begin
            if (wr_tmr) begin
                timer_b_count_q <= pwdata[7:0];
            end else if (period_end) begin
                timer_b_count_q <= `RST_ZERO; // R9
            end else if (tick) begin
                timer_b_count_q <= timer_b_count_q + 8'h01; // R13
            end
            if (period_end) begin
                duty_shadow_q     <= duty_new[9:2]; // R9
                duty_low_shadow_q <= duty_new[1:0];
            end else if (wr && hit(`IDX_DUTY_SHADOW) && !pwm_mode) begin
                duty_shadow_q <= pwdata[7:0];
            end
            if (wr && hit(`IDX_CAPCMP_CONTROL) && pwdata[7:0] == `RST_ZERO) begin
                pwm_latch_q <= 1'b0; // R12
            end else if (!pwm_mode) begin
                pwm_latch_q <= 1'b0;
            end else if (period_end) begin
                pwm_latch_q <= (duty_new != 10'h000); // R9
            end else if (duty_cur == cnt_ext) begin
                // a duty beyond the period never matches, so the pin stays high
                pwm_latch_q <= 1'b0; // R10 R11
            end
        end
    end

    // software registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_control_q        <= `RST_ZERO;
            periph_irq_flags_q   <= `RST_ZERO;
            periph_irq_enables_q <= `RST_ZERO;
            timer_b_control_q    <= `RST_ZERO;
            duty_high_bits_q     <= `RST_ZERO;
            capcmp_control_q     <= `RST_ZERO;
            port_c_direction_q   <= `RST_PORT_C_DIRECTION; // R8
            pwm_period_limit_q   <= `RST_PERIOD_LIMIT;
        end else begin
            if (wr && hit(`IDX_INT_CONTROL)) begin
                int_control_q <= pwdata[7:0];
            end
            if (wr && hit(`IDX_IRQ_ENABLES)) begin
                periph_irq_enables_q <= pwdata[7:0] & `MASK_IRQ; // R7
            end
            if (wr_tbc) begin
                timer_b_control_q <= pwdata[7:0] & `MASK_TIMER_B_CONTROL; // R4 R7
            end
            if (wr && hit(`IDX_DUTY_HIGH_BITS)) begin
                duty_high_bits_q <= pwdata[7:0];
            end
            if (wr && hit(`IDX_CAPCMP_CONTROL)) begin
                capcmp_control_q <= pwdata[7:0] & `MASK_CAPCMP_CONTROL; // R7
            end
            if (wr && hit(`IDX_PORT_C_DIRECTION)) begin
                port_c_direction_q <= pwdata[7:0];
            end
            if (wr && hit(`IDX_PERIOD_LIMIT)) begin
                pwm_period_limit_q <= pwdata[7:0];
            end
            // write one to clear; a match in the same cycle wins
            periph_irq_flags_q <= ((periph_irq_flags_q
                                  & ~((wr && hit(`IDX_IRQ_FLAGS)) ? pwdata[7:0] : 8'h00))
                                  | ({7'h00, period_end} << `IRQ_MATCH_BIT)) & `MASK_IRQ;
        end
    end

    // apb slave: one wait-free access phase, slverr on unmapped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr[11:2])
                    {2'b00, `IDX_INT_CONTROL}:      prdata[7:0] <= int_control_q;
                    {2'b00, `IDX_IRQ_FLAGS}:        prdata[7:0] <= periph_irq_flags_q;
                    {2'b00, `IDX_IRQ_ENABLES}:      prdata[7:0] <= periph_irq_enables_q;
                    {2'b00, `IDX_TIMER_B_COUNT}:    prdata[7:0] <= timer_b_count_q;
                    {2'b00, `IDX_TIMER_B_CONTROL}:  prdata[7:0] <= timer_b_control_q;
                    {2'b00, `IDX_DUTY_HIGH_BITS}:   prdata[7:0] <= duty_high_bits_q;
                    {2'b00, `IDX_DUTY_SHADOW}:      prdata[7:0] <= duty_shadow_q;
                    {2'b00, `IDX_CAPCMP_CONTROL}:   prdata[7:0] <= capcmp_control_q;
                    {2'b00, `IDX_PORT_C_DIRECTION}: prdata[7:0] <= port_c_direction_q;
                    {2'b00, `IDX_PERIOD_LIMIT}:     prdata[7:0] <= pwm_period_limit_q;
                    default:                        pslverr     <= 1'b1;
                endcase
            end
        end
    end

    // pin and interrupt outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out_pin    <= 1'b0;
            pwm_out_pin_oe <= 1'b0;
            irq            <= 1'b0;
        end else begin
            pwm_out_pin    <= pwm_latch_q && !duty_hit
                              && !port_c_direction_q[`PWM_PIN_BIT]; // R3 R10
            pwm_out_pin_oe <= !port_c_direction_q[`PWM_PIN_BIT]; // R3
            irq            <= |(periph_irq_flags_q & periph_irq_enables_q)
                              && int_control_q[`INTC_PEIE] && int_control_q[`INTC_GIE];
        end
    end

endmodule
`default_nettype wire

// File: test/pwm_load_model.sv
`timescale 1ns/10ps
`default_nettype none
// load with a pull-down: a released pin reads low, never the last driven level
module pwm_load_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // pin
    input  wire logic        pin,
    input  wire logic        pin_oe,
    // measurement from one rise to the next
    output logic             stb,
    output logic      [15:0] hi_len,
    output logic      [15:0] per_len
);
    logic        prev_q;
    wire         lvl = pin_oe & pin;
    wire         rise = lvl & !prev_q;
    logic [15:0] cnt_q;
    logic [15:0] hc_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {stb, prev_q, hi_len, per_len, cnt_q, hc_q} <= '0;
        end else begin
            prev_q <= lvl;
            stb <= rise;
            cnt_q <= rise ? 16'h0001 : cnt_q + 16'h0001;
            hc_q <= rise ? 16'h0001 : hc_q + {15'h0000, lvl};
            if (rise) begin
                per_len <= cnt_q;
                hi_len <= hc_q;
            end
        end
    end
endmodule
`default_nettype wire

// File: test/pwm_timer_setup_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_timer_setup_asserts (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pin and interrupt
    input wire logic        pwm_out_pin,
    input wire logic        pwm_out_pin_oe,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pready && pwrite;
    wire rd = psel && penable && pready && !pwrite;
    chk_pin_oe: assert property (pwm_out_pin |-> pwm_out_pin_oe)
        else $error("pin high while released");
    chk_dir_oe: assert property (wr && paddr == 12'h21C |-> ##2 pwm_out_pin_oe != $past(pwdata[2], 2))
        else $error("pin enable does not follow direction bit");
    chk_ccp_clear: assert property (wr && paddr == 12'h05C && pwdata[7:0] == 8'h00 |-> ##2 !pwm_out_pin)
        else $error("pin not low after mode clear");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_ctrl_top: assert property (rd && paddr == 12'h048 |-> !prdata[7])
        else $error("timer control bit 7 not zero");
    chk_ccp_top: assert property (rd && paddr == 12'h05C |-> prdata[7:6] == 2'h0)
        else $error("mode register top bits not zero");
    chk_rdy_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_rdy_access: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    chk_err_quiet: assert property (pslverr |-> pready && prdata == 32'h00000000)
        else $error("error without ready or with data");
endmodule
bind pwm_timer_setup pwm_timer_setup_asserts i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out_pin(pwm_out_pin),
    .pwm_out_pin_oe(pwm_out_pin_oe), .irq(irq));
`default_nettype wire

// File: test/pwm_timer_setup_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_timer_setup_tb;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    wire  [31:0] prdata;
    wire         pready, pslverr, pin, oe, irq, stb;
    wire  [15:0] hi_len, per_len;
    logic [8:0]  rq[$];
    logic [31:0] pq[$];
    integer      failures = 0, n_tests = 0, cyc = 0;
    logic [7:0]  ra[9] = '{8'h87, 8'h92, 8'h12, 8'h17, 8'h0C, 8'h8C, 8'h11, 8'h0B, 8'h00};
    logic [8:0]  rv[9] = '{9'h0FF, 9'h0FF, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h100};
    logic [7:0]  ma[4] = '{8'h12, 8'h17, 8'h8C, 8'h92};
    logic [7:0]  mv[4] = '{8'h7F, 8'h3F, 8'h4F, 8'hFF};
    always #10 pclk = ~pclk;
    pwm_timer_setup i_pwm_timer_setup (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pwm_out_pin(pin), .pwm_out_pin_oe(oe), .irq(irq));
    pwm_load_model i_pwm_load_model (.pclk(pclk), .presetn(presetn), .pin(pin), .pin_oe(oe),
        .stb(stb), .hi_len(hi_len), .per_len(per_len));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task final_report();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            final_report();
        end
    end
    // the oldest queued note, if there is one, is matched against the next read answer or measured period
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'h1 && !pwrite && rq.size() > 0)
            chk("read", rq.pop_front(), {pslverr, prdata[7:0]});
        if (stb === 1'h1 && pq.size() > 0)
            chk("pulse", pq.pop_front(), {hi_len, per_len});
    end
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, 2'h0, i, 2'h0, 24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] i, input logic [8:0] e);
        rq.push_back(e);
        apb(1'h0, i, 8'h00);
    endtask
    task automatic wstb(input integer n);
        integer k;
        k = 0;
        while (k < n) begin
            @(posedge pclk);
            if (stb === 1'h1) k++;
        end
    endtask
    // stop and clear first so a stale duty never leaks into the next period
    task automatic cfg(input logic [7:0] p, input logic [9:0] d, input logic [1:0] ps);
        apb(1'h1, 8'h17, 8'h00);
        apb(1'h1, 8'h12, 8'h00);
        apb(1'h1, 8'h11, 8'h00);
        apb(1'h1, 8'h92, p);
        apb(1'h1, 8'h15, d[9:2]);
        apb(1'h1, 8'h17, {2'h0, d[1:0], 4'h0});
        apb(1'h1, 8'h87, 8'hFB);
        apb(1'h1, 8'h12, {5'h01, ps});
        apb(1'h1, 8'h17, {2'h0, d[1:0], 4'hC});
    endtask
    initial begin
        logic [7:0] p;
        logic [9:0] d;
        integer     ps, bad;
        void'($urandom(32'h1AC0B606));
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        foreach (ra[k]) rd(ra[k], rv[k]);
        foreach (ma[k]) begin
            apb(1'h1, ma[k], 8'hFF);
            rd(ma[k], {1'h0, mv[k]});
            apb(1'h1, ma[k], 8'h00);
        end
        $display("test registers done");
        for (int t = 0; t < 6; t++) begin
            ps = 1 << (2 * (t % 3));
            p = (t == 0) ? 8'hFF : 8'(3 + $urandom % 13);
            d = 10'(1 + $urandom % ((p + 1) * 4 - 1));
            cfg(p, d, 2'(t % 3));
            wstb(2);
            pq.push_back({16'(d * ps), 16'((p + 1) * 4 * ps)});
            wstb(2);
            $display("test pwm %0d done", t);
        end
        for (int k = 0; k < 2; k++) begin
            cfg(8'h03, k ? 10'h3FF : 10'h000, 2'h0);
            repeat (40) @(posedge pclk);
            bad = 0;
            repeat (16) begin
                @(posedge pclk);
                if (pin !== k[0]) bad++;
            end
            chk("steady", 0, bad);
        end
        apb(1'h1, 8'h87, 8'hFF);
        repeat (3) @(posedge pclk);
        chk("released", 0, {oe, pin});
        apb(1'h1, 8'h87, 8'hFB);
        apb(1'h1, 8'h17, 8'h00);
        repeat (3) @(posedge pclk);
        chk("latch low", 0, pin);
        apb(1'h1, 8'h8C, 8'h02);
        apb(1'h1, 8'h0B, 8'hC0);
        repeat (20) @(posedge pclk);
        @(negedge pclk);
        chk("irq set", 1, irq);
        apb(1'h1, 8'h8C, 8'h00);
        @(negedge pclk);
        chk("irq masked", 0, irq);
        apb(1'h1, 8'h12, 8'h00);
        apb(1'h1, 8'h0C, 8'h06);
        apb(1'h1, 8'h8C, 8'h02);
        @(negedge pclk);
        chk("irq clear", 0, irq);
        rd(8'h0C, 9'h000);
        apb(1'h1, 8'h11, 8'h00);
        repeat (20) @(posedge pclk);
        rd(8'h11, 9'h000);
        $display("test pin and irq done");
        final_report();
    end
endmodule
`default_nettype wire
